// file: cmp_defines.vh
// Overview of operation
// - Leaving reset, execution starts in thread mode, never in handler mode.
// - Exceptions run in handler mode; exception return goes back to thread mode.
// - Unprivileged code cannot use change-processor-state; special moves are limited.
// - Unprivileged accesses to tick timer, interrupt controller, control block denied.
// - Privileged code may execute every instruction and reach every resource.
// - Handler mode is always privileged whatever the control register holds.
// - Only privileged code writes the control register selecting thread privilege.
// - Supervisor call works unprivileged and passes control to privileged code.
// - Stacks are full-descending: decrement pointer first, then store at it.
// - Separate main and process stack pointers; R13 means the selected one.
// - Handler mode always uses the main stack pointer.
// - Control bit 1 picks thread stack: 0 main, 1 process; resets to 0.
// - On reset the main stack pointer loads the word at address 0x00000000.
// - On reset the link register is set to all ones.
// - Instruction pointer bit 0 always reads as zero; IP_OUT shows it set from reset until READY rises.
// - On reset the instruction pointer loads the vector word at 0x00000004.
// - Thirteen 32-bit general registers R0 to R12, undefined after reset.
// - Status word holds flags, exception and execution views in disjoint fields.
// - Special moves accept each view alone or any two or all three.
// - Special-move writes to the exception-number bits leave them unchanged.
// - Execution view bits read as zero and ignore writes.
// - Flags view holds N Z C V Q from bit 31 down, set by instructions.
// - Low nine bits hold active exception number, zero in thread mode.
`ifndef CMP_DEFINES_VH
`define CMP_DEFINES_VH

// ==========================================================
// Command codes
`define CMP_OP_GPR_RD   4'h0
`define CMP_OP_GPR_WR   4'h1
`define CMP_OP_SPC_RD   4'h2
`define CMP_OP_SPC_WR   4'h3
`define CMP_OP_CPS      4'h4
`define CMP_OP_SVC      4'h5
`define CMP_OP_EXC_IN   4'h6
`define CMP_OP_EXC_RET  4'h7
`define CMP_OP_PUSH     4'h8
`define CMP_OP_POP      4'h9
`define CMP_OP_FLAGS    4'hA

// ==========================================================
// Register indices and special selectors
`define CMP_GPR_COUNT   4'hD
`define CMP_IDX_SP      4'hD
`define CMP_IDX_LINK    4'hE
`define CMP_IDX_IP      4'hF
`define CMP_SYS_MSP     8'h08
`define CMP_SYS_PSP     8'h09
`define CMP_SYS_CTRL    8'h14

// ==========================================================
// Status word fields
`define CMP_FLAG_HI     31
`define CMP_FLAG_LO     27
`define CMP_EXC_HI      8
`define CMP_EXC_LO      0
`define CMP_TBIT        24
`define CMP_CTRL_NPRIV  0
`define CMP_CTRL_SPSEL  1

// ==========================================================
// Reset values and addresses
`define CMP_RST_MSP     32'h10000000
`define CMP_RST_LINK    32'hFFFFFFFF
`define CMP_RST_IP      32'hFFFFFFFF
`define CMP_RST_PSR     32'h01000000
`define CMP_VEC_SP      32'h00000000
`define CMP_VEC_IP      32'h00000004
`define CMP_WORD        32'h00000004
`define CMP_EXC_THREAD  9'h000
`define CMP_EXC_SVC     9'h00B
`define CMP_SCS_BASE    32'hE000E000
`define CMP_SCS_MASK    32'hFFFFF000

`endif

// file: cmp_gpr_bank.v
`timescale 1ns/10ps
module cmp_gpr_bank (
  input  wire        clk,
  input  wire        we,
  input  wire [3:0]  waddr,
  input  wire [31:0] wdata,
  input  wire [3:0]  raddr,
  output reg  [31:0] rdata
);
  reg [31:0] mem [0:12];

  // No reset: contents are undefined after reset by design
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: cmp_core_regs.v
`timescale 1ns/10ps
`include "cmp_defines.vh"
module cmp_core_regs (
  input  wire        SYS_CLK,
  input  wire        RSTN,
  input  wire        CMD_VALID,
  input  wire [3:0]  CMD_OP,
  input  wire [3:0]  CMD_IDX,
  input  wire [7:0]  CMD_SYSM,
  input  wire [31:0] CMD_WDATA,
  input  wire [8:0]  CMD_EXC,
  input  wire [4:0]  CMD_FLAGS,
  input  wire        FETCH_ACK,
  input  wire [31:0] FETCH_DATA,
  input  wire        PERIPH_VALID,
  input  wire [31:0] PERIPH_ADDR,
  output reg         READY,
  output reg         FETCH_REQ,
  output reg  [31:0] FETCH_ADDR,
  output reg         RVALID,
  output reg  [31:0] RDATA,
  output reg         DENIED,
  output reg         SVC_TAKEN,
  output reg         PERIPH_DENY,
  output reg         HANDLER_MODE,
  output reg         PRIVILEGED,
  output reg         SP_IS_PROCESS,
  output reg  [31:0] SP_OUT,
  output reg  [31:0] IP_OUT,
  output reg  [31:0] PSR_OUT
);
  // ==========================================================
  // States
  localparam [1:0] ST_BOOT_SP = 2'h0;
  localparam [1:0] ST_BOOT_IP = 2'h1;
  localparam [1:0] ST_RUN     = 2'h2;

  reg [1:0]  state_r;
  reg        handler_r;
  reg [1:0]  ctrl_r;
  reg [31:0] msp_r;
  reg [31:0] psp_r;
  reg [31:0] link_r;
  reg [31:0] ip_r;
  reg [4:0]  flags_r;
  reg [8:0]  exc_r;
  reg        tbit_r;
  reg        rd_pend_r;
  reg        rd_mem_r;
  reg [31:0] rd_val_r;

  reg        gpr_we;
  reg [31:0] spc_val;
  reg        spc_deny;

  // ==========================================================
  // Privilege and stack selection
  wire [31:0] gpr_q;
  wire        run   = (state_r == ST_RUN) & CMD_VALID;
  wire        priv  = handler_r | ~ctrl_r[`CMP_CTRL_NPRIV];
  wire        use_p = ~handler_r & ctrl_r[`CMP_CTRL_SPSEL];
  wire [31:0] sp    = use_p ? psp_r : msp_r;

  // ==========================================================
  // Status view decoding
  function is_psr;
    input [7:0] s;
    begin
      is_psr = (s[7:3] == 5'h00) & (s != 8'h04);
    end
  endfunction

  function has_app;
    input [7:0] s;
    begin
      has_app = is_psr(s) & ~s[2];
    end
  endfunction

  function has_exc;
    input [7:0] s;
    begin
      has_exc = is_psr(s) & s[0];
    end
  endfunction

  // Core-private window: tick timer, interrupt controller, control block
  function is_scs_addr;
    input [31:0] a;
    begin
      is_scs_addr = ((a & `CMP_SCS_MASK) == `CMP_SCS_BASE);
    end
  endfunction

  // Selectors that only privileged code may write
  function is_guarded_sel;
    input [7:0] s;
    begin
      is_guarded_sel = (s == `CMP_SYS_MSP) | (s == `CMP_SYS_PSP) | (s == `CMP_SYS_CTRL);
    end
  endfunction

  // One word on the active pointer; push moves down, pop moves up
  function [31:0] stack_step;
    input [31:0] p;
    input        push;
    begin
      stack_step = push ? (p - `CMP_WORD) : (p + `CMP_WORD);
    end
  endfunction

  // Software-visible status: execution bits always hidden
  function [31:0] psr_view;
    input [7:0] s;
    input [4:0] f;
    input [8:0] e;
    reg   [31:0] v;
    begin
      v = 32'h00000000;
      if (has_app(s)) begin
        v[`CMP_FLAG_HI:`CMP_FLAG_LO] = f;
      end
      if (has_exc(s)) begin
        v[`CMP_EXC_HI:`CMP_EXC_LO] = e;
      end
      psr_view = v;
    end
  endfunction

  // ==========================================================
  // Special-register read value and privilege check
  always @* begin
    spc_val  = 32'h00000000;
    spc_deny = 1'b0;
    if (is_psr(CMD_SYSM)) begin
      spc_val = psr_view(CMD_SYSM, flags_r, exc_r);
    end else begin
      case (CMD_SYSM)
        `CMP_SYS_MSP: begin
          spc_val  = priv ? msp_r : 32'h00000000;
          spc_deny = ~priv;
        end
        `CMP_SYS_PSP: begin
          spc_val  = priv ? psp_r : 32'h00000000;
          spc_deny = ~priv;
        end
        `CMP_SYS_CTRL: begin
          spc_val = {30'h00000000, ctrl_r};
        end
        default: begin
          spc_val = 32'h00000000;
        end
      endcase
    end
  end

  // ==========================================================
  // Register bank
  // Indices 13 to 15 are not in the bank; keep its read in range
  wire [3:0] bank_raddr = (CMD_IDX < `CMP_GPR_COUNT) ? CMD_IDX : 4'h0;

  always @* begin
    gpr_we = run & (CMD_OP == `CMP_OP_GPR_WR) & (CMD_IDX < `CMP_GPR_COUNT);
  end

  cmp_gpr_bank u_bank (
    .clk   (SYS_CLK),
    .we    (gpr_we),
    .waddr (CMD_IDX),
    .wdata (CMD_WDATA),
    .raddr (bank_raddr),
    .rdata (gpr_q)
  );

  // ==========================================================
  // Core state
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r    <= ST_BOOT_SP;
      handler_r  <= 1'b0;
      ctrl_r     <= 2'h0;
      msp_r      <= `CMP_RST_MSP;
      psp_r      <= 32'h00000000;
      link_r     <= `CMP_RST_LINK;
      ip_r       <= `CMP_RST_IP;
      flags_r    <= 5'h00;
      exc_r      <= `CMP_EXC_THREAD;
      tbit_r     <= 1'b1;
      FETCH_REQ  <= 1'b1;
      FETCH_ADDR <= `CMP_VEC_SP;
      DENIED     <= 1'b0;
      SVC_TAKEN  <= 1'b0;
      rd_pend_r  <= 1'b0;
      rd_mem_r   <= 1'b0;
      rd_val_r   <= 32'h00000000;
    end else begin
      DENIED    <= 1'b0;
      SVC_TAKEN <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_mem_r  <= 1'b0;
      case (state_r)
        ST_BOOT_SP: begin
          if (FETCH_ACK) begin
            msp_r      <= FETCH_DATA;
            FETCH_ADDR <= `CMP_VEC_IP;
            state_r    <= ST_BOOT_IP;
          end
        end
        ST_BOOT_IP: begin
          if (FETCH_ACK) begin
            ip_r      <= {FETCH_DATA[31:1], 1'b0};
            FETCH_REQ <= 1'b0;
            state_r   <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (CMD_VALID) begin
            case (CMD_OP)
              `CMP_OP_GPR_RD: begin
                rd_pend_r <= 1'b1;
                rd_mem_r  <= (CMD_IDX < `CMP_GPR_COUNT);
                case (CMD_IDX)
                  `CMP_IDX_SP:   rd_val_r <= sp;
                  `CMP_IDX_LINK: rd_val_r <= link_r;
                  `CMP_IDX_IP:   rd_val_r <= ip_r;
                  default:       rd_val_r <= 32'h00000000;
                endcase
              end
              `CMP_OP_GPR_WR: begin
                case (CMD_IDX)
                  `CMP_IDX_SP: begin
                    if (use_p) begin
                      psp_r <= CMD_WDATA;
                    end else begin
                      msp_r <= CMD_WDATA;
                    end
                  end
                  `CMP_IDX_LINK: link_r <= CMD_WDATA;
                  `CMP_IDX_IP:   ip_r   <= {CMD_WDATA[31:1], 1'b0};
                  default: begin
                    link_r <= link_r;
                  end
                endcase
              end
              `CMP_OP_SPC_RD: begin
                rd_pend_r <= 1'b1;
                rd_val_r  <= spc_val;
                DENIED    <= spc_deny;
              end
              `CMP_OP_SPC_WR: begin
                if (has_app(CMD_SYSM)) begin
                  // Exception and execution bits never written here
                  flags_r <= CMD_WDATA[`CMP_FLAG_HI:`CMP_FLAG_LO];
                end else if (is_psr(CMD_SYSM)) begin
                  flags_r <= flags_r;
                end else if (!priv) begin
                  DENIED <= is_guarded_sel(CMD_SYSM);
                end else begin
                  case (CMD_SYSM)
                    `CMP_SYS_MSP:  msp_r  <= CMD_WDATA;
                    `CMP_SYS_PSP:  psp_r  <= CMD_WDATA;
                    `CMP_SYS_CTRL: ctrl_r <= CMD_WDATA[1:0];
                    default:       ctrl_r <= ctrl_r;
                  endcase
                end
              end
              `CMP_OP_CPS: begin
                DENIED <= ~priv;
              end
              `CMP_OP_SVC: begin
                handler_r <= 1'b1;
                exc_r     <= `CMP_EXC_SVC;
                SVC_TAKEN <= 1'b1;
              end
              `CMP_OP_EXC_IN: begin
                if (CMD_EXC != `CMP_EXC_THREAD) begin
                  handler_r <= 1'b1;
                  exc_r     <= CMD_EXC;
                end
              end
              `CMP_OP_EXC_RET: begin
                handler_r <= 1'b0;
                exc_r     <= `CMP_EXC_THREAD;
              end
              `CMP_OP_PUSH: begin
                // Pointer moves first; the store goes to the new address
                if (use_p) begin
                  psp_r <= stack_step(psp_r, 1'b1);
                end else begin
                  msp_r <= stack_step(msp_r, 1'b1);
                end
              end
              `CMP_OP_POP: begin
                if (use_p) begin
                  psp_r <= stack_step(psp_r, 1'b0);
                end else begin
                  msp_r <= stack_step(msp_r, 1'b0);
                end
              end
              `CMP_OP_FLAGS: begin
                // Saturation flag is sticky; only a special write clears it
                flags_r <= {CMD_FLAGS[4:1], flags_r[0] | CMD_FLAGS[0]};
              end
              default: begin
                DENIED <= 1'b0;
              end
            endcase
          end
        end
        default: begin
          state_r <= ST_BOOT_SP;
        end
      endcase
    end
  end

  // ==========================================================
  // Output stage: read data and state mirrors, one cycle behind state
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      READY         <= 1'b0;
      RVALID        <= 1'b0;
      RDATA         <= 32'h00000000;
      PERIPH_DENY   <= 1'b0;
      HANDLER_MODE  <= 1'b0;
      PRIVILEGED    <= 1'b1;
      SP_IS_PROCESS <= 1'b0;
      SP_OUT        <= `CMP_RST_MSP;
      IP_OUT        <= `CMP_RST_IP;
      PSR_OUT       <= `CMP_RST_PSR;
    end else begin
      READY         <= (state_r == ST_RUN);
      RVALID        <= rd_pend_r;
      // Read data holds until the next read answer
      if (rd_pend_r) begin
        RDATA       <= rd_mem_r ? gpr_q : rd_val_r;
      end
      PERIPH_DENY   <= PERIPH_VALID & ~priv & is_scs_addr(PERIPH_ADDR);
      HANDLER_MODE  <= handler_r;
      PRIVILEGED    <= priv;
      SP_IS_PROCESS <= use_p;
      SP_OUT        <= sp;
      IP_OUT        <= ip_r;
      PSR_OUT       <= {flags_r, 2'h0, tbit_r, 15'h0000, exc_r};
    end
  end
endmodule

// file: cmp_regs_chk_asserts.sv
`timescale 1ns/10ps
module cmp_regs_chk (
  input logic        SYS_CLK,
  input logic        RSTN,
  input logic        CMD_VALID,
  input logic [3:0]  CMD_OP,
  input logic [7:0]  CMD_SYSM,
  input logic        FETCH_ACK,
  input logic        PERIPH_VALID,
  input logic [31:0] PERIPH_ADDR,
  input logic        READY,
  input logic        FETCH_REQ,
  input logic [31:0] FETCH_ADDR,
  input logic        RVALID,
  input logic [31:0] RDATA,
  input logic        DENIED,
  input logic        SVC_TAKEN,
  input logic        PERIPH_DENY,
  input logic        HANDLER_MODE,
  input logic        PRIVILEGED,
  input logic        SP_IS_PROCESS,
  input logic [31:0] SP_OUT,
  input logic [31:0] IP_OUT,
  input logic [31:0] PSR_OUT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  wire take = CMD_VALID && READY;
  // ==========================================================
  // Mode and privilege
  a_svc_to_handler: assert property (take && CMD_OP == 4'h5 |=>
    SVC_TAKEN ##1 (HANDLER_MODE && PSR_OUT[8:0] == 9'h00B)) else $error("svc did not enter handler");
  a_return_to_thread: assert property (take && CMD_OP == 4'h7 |->
    ##2 !HANDLER_MODE && PSR_OUT[8:0] == 9'h000) else $error("return left handler mode set");
  a_handler_priv: assert property (HANDLER_MODE |-> PRIVILEGED)
    else $error("handler mode not privileged");
  a_handler_main_sp: assert property (HANDLER_MODE |-> !SP_IS_PROCESS)
    else $error("handler mode on process stack");
  // Mirror lags one edge, so only checked on spaced commands
  a_cps_refused: assert property (take && CMD_OP == 4'h4 &&
    !PRIVILEGED && !$past(take) |=> DENIED) else $error("unprivileged cps not refused");
  a_periph_deny: assert property (PERIPH_VALID && !PRIVILEGED &&
    PERIPH_ADDR[31:12] == 20'hE000E && !$past(take) |=> PERIPH_DENY)
    else $error("protected probe not denied");
  // ==========================================================
  // Registers and boot
  a_exec_reads_zero: assert property (take && CMD_OP == 4'h2 && CMD_SYSM == 8'h06 |->
    ##2 RVALID && RDATA == 32'h0) else $error("execution view read nonzero");
  a_push_full_desc: assert property (take && CMD_OP == 4'h8 && !$past(take) |->
    ##2 SP_OUT == $past(SP_OUT, 2) - 32'h4) else $error("push did not decrement by four");
  a_ip_even: assert property (READY |-> !IP_OUT[0])
    else $error("instruction pointer bit zero set");
  a_boot_order: assert property (FETCH_REQ && FETCH_ACK && FETCH_ADDR == 32'h0 |=>
    FETCH_REQ && FETCH_ADDR == 32'h4) else $error("second vector fetch not at four");
  a_boot_thread: assert property ($rose(READY) |-> !HANDLER_MODE && PRIVILEGED &&
    !SP_IS_PROCESS && PSR_OUT == 32'h01000000) else $error("boot state wrong");
endmodule
bind cmp_core_regs cmp_regs_chk u_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID),
  .CMD_OP(CMD_OP), .CMD_SYSM(CMD_SYSM), .FETCH_ACK(FETCH_ACK), .PERIPH_VALID(PERIPH_VALID),
  .PERIPH_ADDR(PERIPH_ADDR), .READY(READY), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR),
  .RVALID(RVALID), .RDATA(RDATA), .DENIED(DENIED), .SVC_TAKEN(SVC_TAKEN),
  .PERIPH_DENY(PERIPH_DENY), .HANDLER_MODE(HANDLER_MODE), .PRIVILEGED(PRIVILEGED),
  .SP_IS_PROCESS(SP_IS_PROCESS), .SP_OUT(SP_OUT), .IP_OUT(IP_OUT), .PSR_OUT(PSR_OUT));

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        SYS_CLK, RSTN, CMD_VALID, FETCH_ACK, PERIPH_VALID;
  logic [3:0]  CMD_OP, CMD_IDX;
  logic [7:0]  CMD_SYSM;
  logic [31:0] CMD_WDATA, FETCH_DATA, PERIPH_ADDR, msp_v, ip_v, e, p, rdv;
  logic [8:0]  CMD_EXC, x_m;
  logic [4:0]  CMD_FLAGS, f_m;
  wire         READY, FETCH_REQ, RVALID, DENIED, SVC_TAKEN, PERIPH_DENY;
  wire         HANDLER_MODE, PRIVILEGED, SP_IS_PROCESS;
  wire  [31:0] FETCH_ADDR, RDATA, SP_OUT, IP_OUT, PSR_OUT;
  logic        den, supervisor_call, rv, pd;
  int          errors, n_checks, cyc;
  cmp_core_regs uut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
    .CMD_IDX(CMD_IDX), .CMD_SYSM(CMD_SYSM), .CMD_WDATA(CMD_WDATA), .CMD_EXC(CMD_EXC),
    .CMD_FLAGS(CMD_FLAGS), .FETCH_ACK(FETCH_ACK), .FETCH_DATA(FETCH_DATA),
    .PERIPH_VALID(PERIPH_VALID), .PERIPH_ADDR(PERIPH_ADDR), .READY(READY),
    .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR), .RVALID(RVALID), .RDATA(RDATA),
    .DENIED(DENIED), .SVC_TAKEN(SVC_TAKEN), .PERIPH_DENY(PERIPH_DENY),
    .HANDLER_MODE(HANDLER_MODE), .PRIVILEGED(PRIVILEGED), .SP_IS_PROCESS(SP_IS_PROCESS),
    .SP_OUT(SP_OUT), .IP_OUT(IP_OUT), .PSR_OUT(PSR_OUT));
  // ==========================================================
  // Clock, vector responder, pulse catcher, watchdog
  initial begin
    SYS_CLK = 0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  // Ack every other cycle; data line scrambled when not acked
  always @(posedge SYS_CLK) begin
    #1;
    FETCH_ACK = FETCH_REQ === 1'b1 && !FETCH_ACK;
    FETCH_DATA = FETCH_ACK ? (FETCH_ADDR === 32'h0 ? msp_v : ip_v) : $urandom;
  end
  // Pulses are caught sticky so the exact lag does not matter here
  always @(posedge SYS_CLK) begin
    cyc++;
    if (DENIED === 1'b1) den = 1;
    if (SVC_TAKEN === 1'b1) supervisor_call = 1;
    if (PERIPH_DENY === 1'b1) pd = 1;
    if (RVALID === 1'b1) begin
      rv = 1;
      rdv = RDATA;
    end
    if (cyc > 20000) begin
      errors++;
      stop_test;
    end
  end
  // ==========================================================
  // Tasks
  function logic [31:0] view(input logic [7:0] s, input logic [4:0] f, input logic [8:0] x);
    view = 32'h0;
    if (s < 8'h04) view[31:27] = f;
    if (s[0]) view[8:0] = x;
  endfunction
  task chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cmd(input logic [3:0] op, input logic [3:0] idx, input logic [7:0] s, input logic [31:0] wd);
    {CMD_OP, CMD_IDX, CMD_SYSM, CMD_WDATA, CMD_VALID} = {op, idx, s, wd, 1'b1};
    {den, supervisor_call, rv, rdv} = 0;
    @(posedge SYS_CLK);
    #1 CMD_VALID = 0;
    repeat (3) @(posedge SYS_CLK);
    #1;
  endtask
  task probe(input logic [31:0] a, input logic exp);
    {PERIPH_ADDR, PERIPH_VALID, pd} = {a, 1'b1, 1'b0};
    @(posedge SYS_CLK);
    #1 PERIPH_VALID = 0;
    repeat (2) @(posedge SYS_CLK);
    #1 chk("periph_deny", exp, pd);
  endtask
  task views;
    for (int s = 0; s < 8; s++) if (s != 4) begin
      cmd(4'h2, 4'h0, s[7:0], 32'h0);
      chk("status_view", view(s[7:0], f_m, x_m), rdv);
    end
  endtask
  task boot;
    RSTN = 0;
    msp_v = $urandom & 32'hFFFFFFFC;
    ip_v = $urandom | 32'h1;
    repeat (6) @(posedge SYS_CLK);
    #1 RSTN = 1;
    for (int i = 0; i < 50 && READY !== 1'b1; i++) @(posedge SYS_CLK);
    repeat (2) @(posedge SYS_CLK);
    #1 chk("ready", 1, READY);
    chk("main_sp", msp_v, SP_OUT);
    chk("ip", ip_v & 32'hFFFFFFFE, IP_OUT);
    chk("mode", 3'b010, {HANDLER_MODE, PRIVILEGED, SP_IS_PROCESS});
    {f_m, x_m} = 0;
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {errors, n_checks, cyc, den, supervisor_call, rv, pd, rdv, p} = 0;
    {CMD_VALID, CMD_OP, CMD_IDX, CMD_SYSM, CMD_WDATA, CMD_EXC, CMD_FLAGS} = 0;
    {FETCH_ACK, FETCH_DATA, PERIPH_VALID, PERIPH_ADDR, RSTN, msp_v, ip_v} = 0;
    void'($urandom(33828));
    boot;
    cmd(4'h0, 4'hE, 8'h00, 32'h0);
    chk("link", 32'hFFFFFFFF, rdv);
    cmd(4'h0, 4'hD, 8'h00, 32'h0);
    chk("active_sp", msp_v, rdv);
    for (int i = 0; i < 13; i++) begin
      e = $urandom;
      cmd(4'h1, i[3:0], 8'h00, e);
      cmd(4'h0, i[3:0], 8'h00, 32'h0);
      chk("gpr", e, rdv);
    end
    repeat (3) begin
      CMD_FLAGS = $urandom;
      cmd(4'hA, 4'h0, 8'h00, 32'h0);
      f_m = {CMD_FLAGS[4:1], f_m[0] | CMD_FLAGS[0]};
    end
    views;
    e = $urandom;
    cmd(4'h3, 4'h0, 8'h03, e);
    f_m = e[31:27];
    views;
    p = $urandom & 32'hFFFFFFFC;
    cmd(4'h3, 4'h0, 8'h09, p);
    cmd(4'h3, 4'h0, 8'h14, 32'h2);
    chk("psp_sel", {1'b1, p}, {SP_IS_PROCESS, SP_OUT});
    cmd(4'h8, 4'h0, 8'h00, 32'h0);
    chk("push", p - 32'h4, SP_OUT);
    cmd(4'h9, 4'h0, 8'h00, 32'h0);
    chk("pop", p, SP_OUT);
    x_m = 9'h010 + ($urandom % 496);
    CMD_EXC = x_m;
    cmd(4'h6, 4'h0, 8'h00, 32'h0);
    chk("exc_entry", {2'b10, msp_v}, {HANDLER_MODE, SP_IS_PROCESS, SP_OUT});
    chk("psr_word", {f_m, 3'b001, 15'h0000, x_m}, PSR_OUT);
    chk("exc_number", x_m, PSR_OUT[8:0]);
    e = $urandom;
    cmd(4'h3, 4'h0, 8'h01, e);
    f_m = e[31:27];
    views;
    cmd(4'h7, 4'h0, 8'h00, 32'h0);
    x_m = 9'h000;
    chk("exc_return", {2'b01, p}, {HANDLER_MODE, SP_IS_PROCESS, SP_OUT});
    cmd(4'h3, 4'h0, 8'h14, 32'h3);
    chk("unpriv", 0, PRIVILEGED);
    cmd(4'h4, 4'h0, 8'h00, 32'h0);
    chk("cps_deny", 1, den);
    cmd(4'h2, 4'h0, 8'h08, 32'h0);
    chk("msp_rd_deny", {1'b1, 32'h0}, {den, rdv});
    cmd(4'h3, 4'h0, 8'h14, 32'h0);
    chk("ctrl_wr_ignored", 2'b10, {den, PRIVILEGED});
    cmd(4'h3, 4'h0, 8'h00, 32'h0);
    chk("flags_wr_ok", 0, den);
    repeat (6) begin
      e = $urandom;
      if (e[0]) e[31:12] = 20'hE000E;
      probe(e, e[31:12] == 20'hE000E);
    end
    cmd(4'h5, 4'h0, 8'h00, 32'h0);
    chk("svc", {3'b111, 9'h00B}, {supervisor_call, HANDLER_MODE, PRIVILEGED, PSR_OUT[8:0]});
    cmd(4'h4, 4'h0, 8'h00, 32'h0);
    chk("cps_handler", 0, den);
    probe(32'hE000E100, 1'b0);
    cmd(4'h7, 4'h0, 8'h00, 32'h0);
    chk("back_unpriv", 3'b001, {HANDLER_MODE, PRIVILEGED, SP_IS_PROCESS});
    boot;
    stop_test;
  end
endmodule
